// file: cdio_pkg.sv
package cdio_pkg;

	// ****************************************************************
	// Register map and field layout
	// ****************************************************************
	localparam logic [4:0] CDIO_OFS_CTRL = 5'h00;
	localparam logic [4:0] CDIO_OFS_STATUS = 5'h04;
	localparam logic [4:0] CDIO_OFS_IRQ_STAT = 5'h08;
	localparam logic [4:0] CDIO_OFS_IRQ_MASK = 5'h0c;
	localparam int CDIO_CTRL_SEL_LSB = 0;
	localparam int CDIO_CTRL_START = 4;
	localparam int CDIO_CTRL_UP = 5;
	localparam logic [3:0] CDIO_SEL_FORCED_STOP = 4'h4;
	localparam logic [31:0] CDIO_CTRL_RESET = 32'h0000_0000;
	localparam logic [1:0] CDIO_PIN_IDLE = 2'h1; // Stop high, reset low.
	localparam int CDIO_ALARMS = 8;
	localparam logic [7:0] CDIO_NONRESETTABLE = 8'hc0;
	localparam int CDIO_IRQ_ALARM = 0;
	localparam int CDIO_IRQ_FSTOP = 1;
	localparam int CDIO_IRQ_RESET = 2;
	localparam int CDIO_IRQS = 3;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CDIO_CLK_MHZ = 125;
	localparam int CDIO_DEBOUNCE_US = 10;
	localparam int CDIO_DEBOUNCE_CYC = CDIO_DEBOUNCE_US * CDIO_CLK_MHZ;
	localparam logic [10:0] CDIO_DEB_RELOAD = 11'(CDIO_DEBOUNCE_CYC - 1);

	// Pin-side outputs that travel together.
	typedef struct packed {
		logic alarm_n;
		logic ready;
		logic error_ind;
		logic reset_ack;
		logic contactor;
		logic warning;
	} cdio_pins_t;

	typedef enum {CDIO_POWERUP, CDIO_RDY_OFF, CDIO_RDY_ON} cdio_state_t;

endpackage : cdio_pkg

// file: cdio_top.sv
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - The forced stop input acts only while the setting selector reads 4.
// - Forced stop input low enters forced stop, opens the contactor and raises the off warning.
// - Forced stop ends when the forced stop input is high again.
// - Alarm reset clears resettable alarms whose cause has gone and never the fixed subset.
// - Alarm reset with no alarm present puts the unit in ready-off.
// - The alarm output is low while any alarm is latched and high otherwise.
// - The ready output is high while the converter is ready.
// - Ready and error indication outputs are always complementary.
// - Error indication is high on an alarm and while alarm reset is asserted.
// - After power-up ready stays low until the converter reports it is up.
// - Reset acknowledge is high while alarm reset is asserted.
// - A start command closes the contactor output unless forced stop, an alarm or the power-up state holds it open.
module cdio_top
(
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic forced_stop_in,
	input wire logic alarm_reset_in,
	input wire logic [cdio_pkg::CDIO_ALARMS-1:0] alarm_cause_in,
	input wire logic [4:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic irq_out,
	output cdio_pkg::cdio_pins_t pins_out
);
	import cdio_pkg::*;

	// ****************************************************************
	// Input synchronisers and debouncers
	// ****************************************************************
	logic [1:0] raw_in;
	logic [1:0] sync1_q;
	logic [1:0] sync2_q;
	logic [1:0] deb_q;
	logic [10:0] deb_cnt_q [2];
	assign raw_in = {alarm_reset_in, forced_stop_in};

	// Two flops first; only the second one is looked at.
	// They start at the idle pin levels, so no false stop follows reset.
	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			sync1_q <= CDIO_PIN_IDLE;
			sync2_q <= CDIO_PIN_IDLE;
		end
		else
		begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
		end
	end

	// A level is accepted only after it held for the whole debounce time.
	// One process keeps a single driver on the debounced levels.
	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			deb_q <= CDIO_PIN_IDLE;
			for (int i = 0; i < 2; i++)
				deb_cnt_q[i] <= CDIO_DEB_RELOAD;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (sync2_q[i] == deb_q[i])
					deb_cnt_q[i] <= CDIO_DEB_RELOAD;
				else if (deb_cnt_q[i] == 11'h000)
				begin
					deb_q[i] <= sync2_q[i];
					deb_cnt_q[i] <= CDIO_DEB_RELOAD;
				end
				else
					deb_cnt_q[i] <= deb_cnt_q[i] - 11'h001;
			end
		end
	end

	logic fs_level;
	logic res_level;
	logic res_prev_q;
	logic res_rise;
	assign fs_level = deb_q[0];
	assign res_level = deb_q[1];
	assign res_rise = res_level && !res_prev_q;

	// ****************************************************************
	// Control register and forced stop
	// ****************************************************************
	logic [31:0] ctrl_q;
	logic [3:0] selector;
	logic fstop_q;
	logic fstop_d;
	assign selector = ctrl_q[CDIO_CTRL_SEL_LSB +: 4];

	// The selector gates the input, so a stale low level is harmless.
	always_comb
	begin
		fstop_d = 1'b0;
		if (selector == CDIO_SEL_FORCED_STOP)
			fstop_d = !fs_level;
	end

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			fstop_q <= 1'b0;
			res_prev_q <= 1'b0;
		end
		else
		begin
			fstop_q <= fstop_d;
			res_prev_q <= res_level;
		end
	end

	// ****************************************************************
	// Alarm latch
	// ****************************************************************
	logic [CDIO_ALARMS-1:0] alarm_q;
	logic [CDIO_ALARMS-1:0] clearable;
	logic any_alarm;
	assign any_alarm = |alarm_q;
	// Only a resettable alarm whose cause has gone may be cleared.
	assign clearable = ~CDIO_NONRESETTABLE & ~alarm_cause_in;

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
			alarm_q <= '0;
		else if (res_rise)
			alarm_q <= (alarm_q & ~clearable) | alarm_cause_in;
		else
			alarm_q <= alarm_q | alarm_cause_in;
	end

	// ****************************************************************
	// Ready state machine
	// ****************************************************************
	cdio_state_t state_q;
	logic stop_cond;
	assign stop_cond = any_alarm || res_level || fstop_q;

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
			state_q <= CDIO_POWERUP;
		else
		begin
			case (state_q)
				CDIO_POWERUP:
					if (ctrl_q[CDIO_CTRL_UP])
						state_q <= CDIO_RDY_OFF;
				CDIO_RDY_OFF:
					if (!stop_cond)
						state_q <= CDIO_RDY_ON;
				CDIO_RDY_ON:
					if (stop_cond)
						state_q <= CDIO_RDY_OFF;
				default:
					state_q <= CDIO_POWERUP;
			endcase
		end
	end

	// ****************************************************************
	// Pin outputs
	// ****************************************************************
	cdio_pins_t pins_d;
	logic ready_d;

	// Outputs lag the state by one flop so every pin is registered.
	always_comb
	begin
		ready_d = (state_q == CDIO_RDY_ON) && !stop_cond;
		pins_d.alarm_n = !any_alarm;
		pins_d.ready = ready_d;
		pins_d.error_ind = !ready_d;
		pins_d.reset_ack = res_level;
		// Contactor opens on alarm too, protecting the main circuit.
		pins_d.contactor = ctrl_q[CDIO_CTRL_START] && !fstop_q &&
			!any_alarm && (state_q != CDIO_POWERUP);
		pins_d.warning = fstop_q;
	end

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
			pins_out <= '{alarm_n: 1'b1, error_ind: 1'b1, default: 1'b0};
		else
			pins_out <= pins_d;
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************
	logic [CDIO_IRQS-1:0] irq_stat_q;
	logic [CDIO_IRQS-1:0] irq_mask_q;
	logic [CDIO_IRQS-1:0] irq_event;
	logic [CDIO_IRQS-1:0] irq_clr;
	logic bus_wr;
	assign irq_event[CDIO_IRQ_ALARM] = |(alarm_cause_in & ~alarm_q);
	assign irq_event[CDIO_IRQ_FSTOP] = fstop_d && !fstop_q;
	assign irq_event[CDIO_IRQ_RESET] = res_rise;
	assign irq_clr = (bus_wr && avs_address_in == CDIO_OFS_IRQ_STAT &&
		avs_byteenable_in[0]) ? avs_writedata_in[CDIO_IRQS-1:0] : '0;

	// A new event wins over a clear in the same cycle.
	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
			irq_stat_q <= '0;
		else
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_event;
	end

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
			irq_out <= 1'b0;
		else
			irq_out <= |(irq_stat_q & irq_mask_q);
	end

	// ****************************************************************
	// Avalon-MM slave
	// ****************************************************************
	logic ack_q;
	assign bus_wr = avs_write_in && ack_q;

	// One wait cycle per access; the release edge is where data lands.
	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read_in || avs_write_in) && !ack_q;
	end

	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
			avs_waitrequest_out <= 1'b1;
		else
			avs_waitrequest_out <= !((avs_read_in || avs_write_in) &&
				!ack_q);
	end

	// Only the low byte holds writable fields, so lane 0 gates each write.
	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			ctrl_q <= CDIO_CTRL_RESET;
			irq_mask_q <= '0;
		end
		else if (bus_wr && avs_byteenable_in[0])
		begin
			if (avs_address_in == CDIO_OFS_CTRL)
				ctrl_q <= {26'h0, avs_writedata_in[5:0]};
			if (avs_address_in == CDIO_OFS_IRQ_MASK)
				irq_mask_q <= avs_writedata_in[CDIO_IRQS-1:0];
		end
	end

	// Unmapped offsets read as zero and ignore writes.
	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
			avs_readdata_out <= 32'h0;
		else if (avs_read_in && !ack_q)
		begin
			case (avs_address_in)
				CDIO_OFS_CTRL: avs_readdata_out <= ctrl_q;
				CDIO_OFS_STATUS: avs_readdata_out <= {20'h0, 2'(state_q),
					fstop_q, res_level, alarm_q};
				CDIO_OFS_IRQ_STAT: avs_readdata_out <= {29'h0, irq_stat_q};
				CDIO_OFS_IRQ_MASK: avs_readdata_out <= {29'h0, irq_mask_q};
				default: avs_readdata_out <= 32'h0;
			endcase
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_fs_low;
		selector == CDIO_SEL_FORCED_STOP && !fs_level;
	endsequence

	sequence s_fs_open;
		fstop_q ##1 (!pins_out.contactor && pins_out.warning);
	endsequence

	a_fstop_sel_gate: assert property (@(posedge clock_in)
		disable iff (!resetn_in)
		selector != CDIO_SEL_FORCED_STOP |=> !fstop_q)
		else $error("Forced stop active with wrong selector.");

	a_fstop_enter_open: assert property (@(posedge clock_in)
		disable iff (!resetn_in)
		s_fs_low |=> s_fs_open)
		else $error("Forced stop did not open contactor.");

	a_fstop_leave: assert property (@(posedge clock_in)
		disable iff (!resetn_in)
		fs_level |=> !fstop_q)
		else $error("Forced stop held after input high.");

	a_alarm_keep: assert property (@(posedge clock_in)
		disable iff (!resetn_in)
		|(alarm_q & CDIO_NONRESETTABLE) |=>
		(alarm_q & CDIO_NONRESETTABLE) == ($past(alarm_q) & CDIO_NONRESETTABLE))
		else $error("Fixed alarm was cleared.");

	a_alarm_pin: assert property (@(posedge clock_in)
		disable iff (!resetn_in)
		1'b1 |=> pins_out.alarm_n == !$past(any_alarm))
		else $error("Alarm output disagrees with latch.");

	a_ready_compl: assert property (@(posedge clock_in)
		disable iff (!resetn_in)
		pins_out.ready != pins_out.error_ind)
		else $error("Ready and error indication not complementary.");

	a_error_on_reset: assert property (@(posedge clock_in)
		disable iff (!resetn_in)
		res_level |=> pins_out.error_ind && pins_out.reset_ack)
		else $error("Reset input did not raise error and ack.");

	a_powerup_hold: assert property (@(posedge clock_in)
		disable iff (!resetn_in)
		state_q == CDIO_POWERUP |=> !pins_out.ready)
		else $error("Ready rose before converter up.");

	a_start_close: assert property (@(posedge clock_in)
		disable iff (!resetn_in)
		ctrl_q[CDIO_CTRL_START] && !fstop_q && !any_alarm &&
		state_q != CDIO_POWERUP |=> pins_out.contactor)
		else $error("Start command did not close contactor.");

	a_alarm_latch: assert property (@(posedge clock_in)
		disable iff (!resetn_in)
		|alarm_q && !res_rise |=> (alarm_q & $past(alarm_q)) == $past(alarm_q))
		else $error("Alarm dropped without reset.");

endmodule : cdio_top
`default_nettype wire

// file: cdio_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Far-side control sequence
// ****************************************************************
module cdio_partner
#(
	parameter int HOLD_CYC = 1400
)
(
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic stop_req_in,
	input wire logic reset_req_in,
	output logic forced_stop_out,
	output logic alarm_reset_out
);
	int hold_q;
	// The reset pin is held for a minimum time even if the request is short.
	// Scaled down from real time so the run stays short.
	always_ff @(posedge clock_in)
	begin
		forced_stop_out <= !stop_req_in;
		if (!resetn_in)
		begin
			alarm_reset_out <= 1'b0;
			hold_q <= 0;
		end
		else if (reset_req_in && !alarm_reset_out)
		begin
			alarm_reset_out <= 1'b1;
			hold_q <= HOLD_CYC;
		end
		else if (hold_q != 0)
			hold_q <= hold_q - 1;
		else if (!reset_req_in)
			alarm_reset_out <= 1'b0;
	end
endmodule : cdio_partner
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cdio_pkg::*;
	logic clock_in = 0, resetn_in = 0, stop_req = 0, reset_req = 0;
	logic rd = 0, wr = 0, fs, ar, wait_o, irq;
	logic [4:0] addr = 0;
	logic [3:0] be = 4'hf;
	logic [7:0] cause = 0;
	logic [31:0] wdata = 0, rdata, q;
	cdio_pins_t pins;
	int failures = 0, n_tests = 0, idx;

	// ****************************************************************
	// Clock, design and far side
	// ****************************************************************
	always #4 clock_in = !clock_in;
	cdio_top i_cdio_top (.clock_in(clock_in), .resetn_in(resetn_in),
		.forced_stop_in(fs), .alarm_reset_in(ar), .alarm_cause_in(cause),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdata), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
		.irq_out(irq), .pins_out(pins));
	cdio_partner i_cdio_partner (.clock_in(clock_in), .resetn_in(resetn_in),
		.stop_req_in(stop_req), .reset_req_in(reset_req),
		.forced_stop_out(fs), .alarm_reset_out(ar));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Avalon access; request held until waitrequest is seen low at an edge.
	task automatic bus(input logic [4:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		@(posedge clock_in);
		while (wait_o !== 1'b0)
		begin
			n++;
			if (n > 50)
			begin
				failures++;
				tally_and_finish();
			end
			@(posedge clock_in);
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clock_in);
	endtask : bus

	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask : tick

	// Ready and error indication are worked out as a complementary pair.
	function automatic logic [31:0] pex(logic alarm_out, logic rdy, logic rst,
		logic con, logic warn);
		return {26'h0, !alarm_out, rdy, !rdy, rst, con, warn};
	endfunction : pex

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		void'($urandom(29219));
		tick(12);
		resetn_in <= 1'b1;
		tick(2);
		check(32'(pins), pex(0, 0, 0, 0, 0));
		bus(CDIO_OFS_CTRL, 0, 0);
		check(q, CDIO_CTRL_RESET);
		bus(5'h10, 1, 32'hff);
		bus(5'h10, 0, 0);
		check(q, 32'h0);
		// A write without lane 0 must leave the control register alone.
		be <= 4'he;
		bus(CDIO_OFS_CTRL, 1, 32'h3f);
		be <= 4'hf;
		bus(CDIO_OFS_CTRL, 0, 0);
		check(q, CDIO_CTRL_RESET);
		$display("test 1 done");
		bus(CDIO_OFS_CTRL, 1, 32'h34);
		tick(3);
		check(32'(pins), pex(0, 1, 0, 1, 0));
		bus(CDIO_OFS_IRQ_MASK, 1, 32'h2);
		stop_req <= 1'b1;
		tick(1300);
		check(32'(pins), pex(0, 0, 0, 0, 1));
		check(32'(irq), 32'h1);
		bus(CDIO_OFS_IRQ_STAT, 1, 32'h2);
		tick(2);
		check(32'(irq), 32'h0);
		stop_req <= 1'b0;
		tick(1300);
		check(32'({pins.warning, pins.ready}), 32'h1);
		$display("test 2 done");
		// A selector other than four leaves the stop pin without effect.
		bus(CDIO_OFS_CTRL, 1, 32'h30 | 32'($urandom_range(0, 3)));
		stop_req <= 1'b1;
		tick(1300);
		check(32'({pins.warning, pins.contactor}), 32'h1);
		stop_req <= 1'b0;
		reset_req <= 1'b1;
		tick(1300);
		check(32'(pins), pex(0, 0, 1, 1, 0));
		reset_req <= 1'b0;
		tick(1500);
		$display("test 3 done");
		idx = $urandom_range(0, 5);
		cause <= 8'h80 | (8'h1 << idx);
		tick(3);
		check(32'({pins.alarm_n, pins.error_ind, pins.contactor}), 32'h2);
		reset_req <= 1'b1;
		tick(1300);
		check(32'(pins.reset_ack), 32'h1);
		reset_req <= 1'b0;
		tick(1500);
		bus(CDIO_OFS_STATUS, 0, 0);
		check(q & 32'hff, 32'h80 | (32'h1 << idx));
		cause <= 8'h0;
		reset_req <= 1'b1;
		tick(1500);
		reset_req <= 1'b0;
		tick(1500);
		bus(CDIO_OFS_STATUS, 0, 0);
		check(q & 32'hff, 32'h80);
		check(32'({pins.alarm_n, pins.error_ind}), 32'h1);
		// New alarm and reset rise are sticky while masked; stop was cleared.
		bus(CDIO_OFS_IRQ_STAT, 0, 0);
		check(q, (32'h1 << CDIO_IRQ_ALARM) | (32'h1 << CDIO_IRQ_RESET));
		check(32'(irq), 32'h0);
		$display("test 4 done");
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
